/* gtm_timer.sv */
`timescale 1ns/1ps
// Overview of operation
// - Clock source field picks LF oscillator, pin rising edge, system or instruction clock.
// - Prescale field divides selected clock by 1, 2, 4 or 8.
// - Bypass bit is stored only; the asynchronous input is synchronised whether it is 0 or 1.
// - Timer control bits 3 and 1 read zero and ignore writes.
// - Run bit starts the timer; clearing stops it and clears gate flip-flop.
// - Gate enable ignored when off; when on, counting follows the gate.
// - Gate polarity 1 counts while gate high, 0 while gate low.
// - Toggle mode bit enables toggling; clearing holds the flip-flop clear.
// - In toggle mode the flip-flop flips on every rising gate edge.
// - Single-pulse bit enables single-pulse mode controlling the gate.
// - Acquire status reads 1 while armed, 0 when done or unstarted.
// - Gate level status is read-only, shows gate level regardless of enable.
// - Control, gate and count fields reset to zero on power-on reset and on presetn.
// - Gate source: pin, companion overflow, comparator output, reserved.
// - Armed acquisition clears on trailing pulse edge, blocking until rearmed.
// - Each falling edge of the gate level sets the gate event flag.
// - Counter rolls FFFF to 0000 and sets the overflow flag.
module gtm_timer
(
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Power-on reset indicator
   input  wire logic        por_event,
   // Clock sources
   input  wire logic        low_freq_internal_osc,
   input  wire logic        external_clock_pin,
   // Gate sources
   input  wire logic        external_gate_pin,
   input  wire logic        tmr0_overflow,
   input  wire logic        comparator_sync_output,
   // Interrupt
   output logic             irq
);
   import gtm_pkg::*;

   typedef struct packed
   {
      logic [7:0]  ctrl;
      logic [7:0]  gate;
      logic [15:0] count;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
      logic [1:0]  div4;
      logic        clk_prev;
      logic        gsrc_prev;
      logic        gtog;
      logic        gval;
      logic        gval_prev;
      logic        gfire;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
      logic        irq;
   } gtm_state_s;

   gtm_state_s st;
   gtm_state_s next_st;

   logic lfo_s;
   logic ckp_s;
   logic gpin_s;
   logic por_q;
   logic clk_lvl;
   logic clk_rise;
   logic tick_raw;
   logic tick;
   logic gsrc;
   logic gpol;
   logic gtog_eff;
   logic gval_new;
   logic cnt_en;
   logic wr;
   logic rd;

   function automatic logic [31:0] rd_mux(input gtm_state_s s, input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         ADDR_TIMER_CONTROL:      v[7:0] = s.ctrl & CTRL_WMASK;
         ADDR_TIMER_GATE_CONTROL: v[7:0] = {s.gate[7:3], s.gval, s.gate[1:0]};
         ADDR_COUNT_LOW:          v[7:0] = s.count[7:0];
         ADDR_COUNT_HIGH:         v[7:0] = s.count[15:8];
         ADDR_IRQ_STATUS:         v[1:0] = s.irq_stat;
         ADDR_IRQ_MASK:           v[1:0] = s.irq_mask;
         default:                 v = 32'h0;
      endcase
      return v;
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      return (a == ADDR_TIMER_CONTROL) || (a == ADDR_TIMER_GATE_CONTROL) ||
             (a == ADDR_COUNT_LOW) || (a == ADDR_COUNT_HIGH) ||
             (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
   endfunction

   gtm_sync2 u_sync_lfo (.pclk(pclk), .presetn(presetn), .d(low_freq_internal_osc),
                         .q(lfo_s));
   gtm_sync2 u_sync_ckp (.pclk(pclk), .presetn(presetn), .d(external_clock_pin),
                         .q(ckp_s));
   gtm_sync2 u_sync_gpin (.pclk(pclk), .presetn(presetn), .d(external_gate_pin),
                          .q(gpin_s));
   gtm_sync2 u_sync_por (.pclk(pclk), .presetn(presetn), .d(por_event), .q(por_q));

   gtm_prescale u_ps
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (!st.ctrl[RUN_POS]),
      .ratio    (st.ctrl[PS_POS +: 2]),
      .tick_in  (tick_raw),
      .tick_out (tick)
   );

   always_comb
   begin
      // Clock source selection
      clk_lvl  = (st.ctrl[CS_POS +: 2] == CS_LFOSC) ? lfo_s : ckp_s;
      // With bypass the pin is edge-detected after the same two stages; no deeper sync
      clk_rise = clk_lvl && !st.clk_prev;
      case (st.ctrl[CS_POS +: 2])
         CS_INSTR: tick_raw = (st.div4 == INSTR_DIV_LAST);
         CS_SYS:   tick_raw = 1'b1;
         CS_PIN:   tick_raw = clk_rise;
         CS_LFOSC: tick_raw = clk_rise;
         default:  tick_raw = 1'b0;
      endcase
      // Gate path
      case (st.gate[GSS_POS +: 2])
         GS_PIN:  gsrc = gpin_s;
         GS_TMR0: gsrc = tmr0_overflow;
         GS_CMP:  gsrc = comparator_sync_output;
         default: gsrc = 1'b0;
      endcase
      gpol     = st.gate[GPOL_POS] ? gsrc : !gsrc;
      gtog_eff = st.gate[GTM_POS] ? st.gtog : gpol;
      gval_new = st.gate[GSPM_POS] ? (gtog_eff && st.gate[GO_POS]) : gtog_eff;
      cnt_en   = st.ctrl[RUN_POS] && (!st.gate[GE_POS] || st.gval);
      wr = psel && penable && pwrite && st.ready;
      rd = psel && !penable;
   end

   always_comb
   begin
      next_st          = st;
      next_st.clk_prev = clk_lvl;
      next_st.div4     = 2'(st.div4 + 2'h1);
      next_st.gsrc_prev = gpol;
      next_st.gval     = gval_new;
      next_st.gval_prev = st.gval;
      // Toggle flip-flop
      if (!st.gate[GTM_POS] || !st.ctrl[RUN_POS])
         next_st.gtog = 1'b0;
      else if (gpol && !st.gsrc_prev)
         next_st.gtog = !st.gtog;
      // Counter
      if (cnt_en && tick)
      begin
         next_st.count = 16'(st.count + 16'h1);
         if (st.count == COUNT_MAX)
            next_st.irq_stat[IRQ_OVF_POS] = 1'b1;
      end
      // APB
      next_st.ready  = psel && penable && !st.ready;
      next_st.slverr = psel && penable && !st.ready && !addr_ok(paddr);
      if (rd)
         next_st.rdata = rd_mux(st, paddr);
      if (wr)
      begin
         case (paddr)
            ADDR_TIMER_CONTROL:
               next_st.ctrl = pwdata[7:0] & CTRL_WMASK;
            ADDR_TIMER_GATE_CONTROL:
               next_st.gate = {pwdata[7:4], pwdata[GO_POS] & pwdata[GSPM_POS], 1'b0,
                               pwdata[1:0]} & {GATE_WMASK[7:4], 1'b1, GATE_WMASK[2:0]};
            ADDR_COUNT_LOW:  next_st.count[7:0]  = pwdata[7:0];
            ADDR_COUNT_HIGH: next_st.count[15:8] = pwdata[7:0];
            ADDR_IRQ_STATUS: next_st.irq_stat    = st.irq_stat & ~pwdata[1:0];
            ADDR_IRQ_MASK:   next_st.irq_mask    = pwdata[1:0];
            default: ;
         endcase
      end
      // Single-pulse done on trailing edge; hardware clear wins
      if (st.gate[GSPM_POS] && st.gate[GO_POS] && st.gval_prev && !st.gval)
         next_st.gate[GO_POS] = 1'b0;
      if (!gval_new && st.gval)
         next_st.irq_stat[IRQ_GATE_POS] = 1'b1;
      if (cnt_en && tick && st.count == COUNT_MAX)
         next_st.irq_stat[IRQ_OVF_POS] = 1'b1;
      next_st.gfire = !gval_new && st.gval;
      next_st.irq   = |(next_st.irq_stat & next_st.irq_mask);
      // Power-on/brown-out clears ctrl, gate and count; presetn clears them as well
      if (por_q)
      begin
         next_st.ctrl  = CTRL_RESET;
         next_st.gate  = GATE_RESET;
         next_st.count = COUNT_RESET;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st       <= '0;
         st.ctrl  <= CTRL_RESET;
         st.gate  <= GATE_RESET;
      end
      else
         st <= next_st;
   end

   assign prdata  = st.rdata;
   assign pready  = st.ready;
   assign pslverr = st.slverr;
   assign irq     = st.irq;

   // Checks
   property p_overflow_flag;
      @(posedge pclk) disable iff (!presetn)
      (cnt_en && tick && st.count == COUNT_MAX && !por_q) |=>
         (st.count == 16'h0000) && st.irq_stat[IRQ_OVF_POS];
   endproperty
   a_overflow_flag: assert property (p_overflow_flag) else $error("overflow wrong");

   property p_stop_holds;
      @(posedge pclk) disable iff (!presetn)
      (!st.ctrl[RUN_POS] && !wr && !por_q) |=> $stable(st.count);
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("count moved when off");

   property p_toggle_clear;
      @(posedge pclk) disable iff (!presetn)
      !st.gate[GTM_POS] |=> !st.gtog;
   endproperty
   a_toggle_clear: assert property (p_toggle_clear) else $error("toggle not clear");

   property p_gate_fall;
      @(posedge pclk) disable iff (!presetn)
      $fell(st.gval) |=> st.irq_stat[IRQ_GATE_POS];
   endproperty
   a_gate_fall: assert property (p_gate_fall) else $error("gate flag missing");

   property p_ctrl_unimpl;
      @(posedge pclk) disable iff (!presetn)
      st.ctrl[3] == 1'b0 && st.ctrl[1] == 1'b0;
   endproperty
   a_ctrl_unimpl: assert property (p_ctrl_unimpl) else $error("unimplemented bit set");

   sequence s_armed_fall;
      st.gate[GSPM_POS] && st.gate[GO_POS] && st.gval_prev && !st.gval;
   endsequence
   property p_pulse_done;
      @(posedge pclk) disable iff (!presetn)
      s_armed_fall |=> !st.gate[GO_POS];
   endproperty
   a_pulse_done: assert property (p_pulse_done) else $error("acquire not cleared");

   property p_gate_enable;
      @(posedge pclk) disable iff (!presetn)
      (st.ctrl[RUN_POS] && st.gate[GE_POS] && !st.gval && !wr && !por_q) |=>
         $stable(st.count);
   endproperty
   a_gate_enable: assert property (p_gate_enable) else $error("counted while gated");

   property p_irq_level;
      @(posedge pclk) disable iff (!presetn)
      ##1 irq == |($past(next_st.irq_stat) & $past(next_st.irq_mask));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

   property p_sys_prescale;
      @(posedge pclk) disable iff (!presetn)
      (st.ctrl == 8'h41 && st.gate[GE_POS] == 1'b0 && !wr && !por_q) |=>
         st.count == 16'($past(st.count) + 16'h1);
   endproperty
   a_sys_prescale: assert property (p_sys_prescale) else $error("sysclk count");

   property p_toggle_run_off;
      @(posedge pclk) disable iff (!presetn)
      !st.ctrl[RUN_POS] |=> !st.gtog;
   endproperty
   a_toggle_run_off: assert property (p_toggle_run_off) else $error("toggle kept when off");

   property p_ctrl_write;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ADDR_TIMER_CONTROL && !por_q) |=>
         st.ctrl == ($past(pwdata[7:0]) & CTRL_WMASK);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write wrong");

   property p_gate_level;
      @(posedge pclk) disable iff (!presetn)
      (!st.gate[GTM_POS] && !st.gate[GSPM_POS]) |=> st.gval == $past(gpol);
   endproperty
   a_gate_level: assert property (p_gate_level) else $error("gate level wrong");

   property p_single_block;
      @(posedge pclk) disable iff (!presetn)
      (st.gate[GSPM_POS] && !st.gate[GO_POS]) |=> !st.gval;
   endproperty
   a_single_block: assert property (p_single_block) else $error("gate open unarmed");

   sequence s_gate_rise;
      st.gate[GTM_POS] && st.ctrl[RUN_POS] && gpol && !st.gsrc_prev;
   endsequence
   property p_toggle_flip;
      @(posedge pclk) disable iff (!presetn)
      s_gate_rise |=> st.gtog != $past(st.gtog);
   endproperty
   a_toggle_flip: assert property (p_toggle_flip) else $error("toggle missed edge");

   property p_por_clear;
      @(posedge pclk) disable iff (!presetn)
      por_q |=> (st.ctrl == CTRL_RESET) && (st.gate == GATE_RESET);
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("por did not clear");

   property p_ready_pulse;
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");

   property p_err_with_ready;
      @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
endmodule

/* gtm_pkg.sv */
package gtm_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_TIMER_CONTROL      = 8'h00;
   localparam logic [7:0] ADDR_TIMER_GATE_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_COUNT_LOW          = 8'h08;
   localparam logic [7:0] ADDR_COUNT_HIGH         = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STATUS         = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK           = 8'h14;
   // Timer control fields
   localparam int CS_POS     = 6;
   localparam int PS_POS     = 4;
   localparam int SYNC_POS   = 2;
   localparam int RUN_POS    = 0;
   localparam logic [7:0] CTRL_WMASK = 8'hf5;
   // Gate control fields
   localparam int GE_POS     = 7;
   localparam int GPOL_POS   = 6;
   localparam int GTM_POS    = 5;
   localparam int GSPM_POS   = 4;
   localparam int GO_POS     = 3;
   localparam int GVAL_POS   = 2;
   localparam int GSS_POS    = 0;
   localparam logic [7:0] GATE_WMASK = 8'hf3;
   // Interrupt status bits
   localparam int IRQ_OVF_POS  = 0;
   localparam int IRQ_GATE_POS = 1;
   // Reset values
   localparam logic [7:0]  CTRL_RESET  = 8'h00;
   localparam logic [7:0]  GATE_RESET  = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   // Clock sources
   localparam logic [1:0] CS_INSTR = 2'h0;
   localparam logic [1:0] CS_SYS   = 2'h1;
   localparam logic [1:0] CS_PIN   = 2'h2;
   localparam logic [1:0] CS_LFOSC = 2'h3;
   // Gate sources
   localparam logic [1:0] GS_PIN  = 2'h0;
   localparam logic [1:0] GS_TMR0 = 2'h1;
   localparam logic [1:0] GS_CMP  = 2'h2;
   // Instruction clock divide
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage

/* gtm_sync2.sv */
`timescale 1ns/1ps
module gtm_sync2
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Data
   input  wire logic d,
   output logic      q
);
   typedef struct packed
   {
      logic s1;
      logic s2;
   } gtm_sync_s;

   gtm_sync_s st;
   gtm_sync_s next_st;

   always_comb
   begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st <= '0;
      else
         st <= next_st;
   end

   assign q = st.s2;
endmodule

/* gtm_prescale.sv */
`timescale 1ns/1ps
module gtm_prescale
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       clear,
   input  wire logic [1:0] ratio,
   input  wire logic       tick_in,
   output logic            tick_out
);
   typedef struct packed
   {
      logic [2:0] cnt;
   } gtm_ps_s;

   gtm_ps_s st;
   gtm_ps_s next_st;
   logic [2:0] last;

   always_comb
   begin
      last    = 3'((4'h1 << ratio) - 4'h1);
      next_st = st;
      if (clear)
         next_st.cnt = 3'h0;
      else if (tick_in)
         next_st.cnt = (st.cnt >= last) ? 3'h0 : 3'(st.cnt + 3'h1);
   end

   assign tick_out = tick_in && !clear && (st.cnt >= last);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st <= '0;
      else
         st <= next_st;
   end
endmodule

/* gtm_far_side.sv */
`timescale 1ns/1ps
module gtm_far_side
(
   // Bench controls
   input  wire logic pclk,
   input  wire logic ext_on,
   input  wire logic gate_drv,
   input  wire logic cmp_drv,
   input  wire logic ovf_req,
   // Clock and gate sources
   output logic      external_clock_pin,
   output logic      low_freq_internal_osc,
   output logic      external_gate_pin,
   output logic      tmr0_overflow,
   output logic      comparator_sync_output
);
   logic ovf_d;
   initial
   begin
      {external_clock_pin, low_freq_internal_osc} = 2'h0;
      {tmr0_overflow, comparator_sync_output, ovf_d} = 3'h0;
   end
   // Pin clock stands still outside runs
   always #20 external_clock_pin = ext_on & ~external_clock_pin;
   always #50 low_freq_internal_osc = ~low_freq_internal_osc;
   assign external_gate_pin = gate_drv;
   // One-cycle companion overflow pulse
   always @(posedge pclk)
   begin
      ovf_d <= ovf_req;
      tmr0_overflow <= ovf_req & ~ovf_d;
      comparator_sync_output <= cmp_drv;
   end
endmodule

/* gated_16bit_timer_control_test.sv */
`timescale 1ns/1ps
module gated_16bit_timer_control_test;
   import gtm_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        por_event = 1'b0;
   logic        ext_on = 1'b0;
   logic        gate_drv = 1'b0;
   logic        cmp_drv = 1'b0;
   logic        ovf_req = 1'b0;
   logic        low_freq_internal_osc, external_clock_pin, external_gate_pin;
   logic        tmr0_overflow, comparator_sync_output;
   logic [31:0] rdat;
   logic        rerr;
   logic [15:0] c;
   logic [15:0] c1;
   int          n_errors = 0;
   int          checks_done = 0;
   int          cyc;
   int          per [4] = '{4, 1, 8, 20};
   always #2.5 pclk = ~pclk;
   gtm_timer i_gtm_timer
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .por_event, .low_freq_internal_osc,
      .external_clock_pin, .external_gate_pin, .tmr0_overflow,
      .comparator_sync_output, .irq
   );
   gtm_far_side i_gtm_far_side
   (
      .pclk, .ext_on, .gate_drv, .cmp_drv, .ovf_req, .external_clock_pin,
      .low_freq_internal_osc, .external_gate_pin, .tmr0_overflow,
      .comparator_sync_output
   );
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, x, g);
      end
   endtask
   task automatic rng(input string s, input int x, input logic [15:0] g);
      checks_done++;
      if ((g + 3 >= x && g <= x + 3) !== 1'b1)
      begin
         n_errors++;
         $display("Error %s expected %0d seen %0d", s, x, g);
      end
   endtask
   task automatic count(output logic [15:0] v);
      apb(1'b0, ADDR_COUNT_LOW, 32'h0);
      v[7:0] = rdat[7:0];
      apb(1'b0, ADDR_COUNT_HIGH, 32'h0);
      v[15:8] = rdat[7:0];
   endtask
   task automatic meas(input logic [7:0] ct, input int n, output logic [15:0] v);
      apb(1'b1, ADDR_COUNT_LOW, 32'h0);
      apb(1'b1, ADDR_COUNT_HIGH, 32'h0);
      apb(1'b1, ADDR_TIMER_CONTROL, {24'h0, ct | 8'h01});
      repeat (n) @(posedge pclk);
      apb(1'b1, ADDR_TIMER_CONTROL, {24'h0, ct});
      count(v);
   endtask
   // Short width is a companion overflow pulse, longer a gate pin pulse
   task automatic pulse(input int h);
      gate_drv <= h > 1;
      ovf_req  <= h == 1;
      repeat (h) @(posedge pclk);
      gate_drv <= 1'b0;
      ovf_req  <= 1'b0;
      repeat (100 - h) @(posedge pclk);
   endtask
   task automatic report_and_stop();
      $display("Checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #300000;
      n_errors++;
      report_and_stop();
   end
   initial
   begin
      void'($urandom(5775));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_TIMER_CONTROL, 32'h0);
      chk("ctrl", 32'(CTRL_RESET), rdat);
      apb(1'b1, ADDR_TIMER_CONTROL, 32'hfe);
      apb(1'b0, ADDR_TIMER_CONTROL, 32'h0);
      chk("ctrl", 32'hf4, rdat);
      apb(1'b1, ADDR_TIMER_GATE_CONTROL, 32'hfa);
      apb(1'b0, ADDR_TIMER_GATE_CONTROL, 32'h0);
      chk("gate", 32'hfa, rdat & 32'hfb);
      por_event <= 1'b1;
      repeat (4) @(posedge pclk);
      por_event <= 1'b0;
      apb(1'b0, ADDR_TIMER_GATE_CONTROL, 32'h0);
      chk("gate", 32'h0, rdat & 32'hfb);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'h1, 32'(rerr));
      // Every clock source, prescale and bypass setting
      for (int i = 0; i < 32; i++)
      begin
         cyc = 400 + $urandom_range(79, 0);
         ext_on <= i[3:2] == 2'h2;
         meas({i[3:2], i[1:0], 1'b0, i[4], 2'h0}, cyc, c);
         rng("count", (cyc + 3) / (per[i[3:2]] << i[1:0]), c);
      end
      ext_on <= 1'b0;
      // Gate enable, polarity, pin and comparator sources
      for (int i = 0; i < 16; i++)
      begin
         gate_drv <= i[1];
         cmp_drv  <= i[1];
         apb(1'b1, ADDR_TIMER_GATE_CONTROL, {24'h0, i[3], i[2], 4'h0, i[0], 1'b0});
         meas(8'h40, 100, c);
         rng("gated", (!i[3] || i[1] == i[2]) ? 103 : 0, c);
         apb(1'b0, ADDR_TIMER_GATE_CONTROL, 32'h0);
         chk("level", 32'(i[1] == i[2]), 32'(rdat[GVAL_POS]));
      end
      gate_drv <= 1'b0;
      // Toggle mode on companion overflow pulses
      apb(1'b1, ADDR_TIMER_GATE_CONTROL, 32'he1);
      apb(1'b1, ADDR_COUNT_LOW, 32'h0);
      apb(1'b1, ADDR_COUNT_HIGH, 32'h0);
      apb(1'b1, ADDR_TIMER_CONTROL, 32'h41);
      repeat (3) pulse(1);
      apb(1'b1, ADDR_TIMER_CONTROL, 32'h40);
      count(c1);
      rng("toggle", 203, c1);
      apb(1'b1, ADDR_TIMER_CONTROL, 32'h41);
      repeat (50) @(posedge pclk);
      apb(1'b1, ADDR_TIMER_CONTROL, 32'h40);
      count(c);
      chk("stopped", 32'(c1), 32'(c));
      // Single pulse acquisition
      apb(1'b1, ADDR_COUNT_LOW, 32'h0);
      apb(1'b1, ADDR_COUNT_HIGH, 32'h0);
      apb(1'b1, ADDR_TIMER_GATE_CONTROL, 32'hd8);
      apb(1'b1, ADDR_TIMER_CONTROL, 32'h41);
      apb(1'b0, ADDR_TIMER_GATE_CONTROL, 32'h0);
      chk("armed", 32'h1, 32'(rdat[GO_POS]));
      repeat (2) pulse(60);
      apb(1'b0, ADDR_TIMER_GATE_CONTROL, 32'h0);
      chk("armed", 32'h0, 32'(rdat[GO_POS]));
      count(c);
      rng("single", 60, c);
      // Interrupts
      apb(1'b1, ADDR_IRQ_MASK, 32'h3);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("gate_evt", 32'h2, rdat & 32'h2);
      chk("irq", 32'h1, 32'(irq));
      apb(1'b1, ADDR_TIMER_CONTROL, 32'h40);
      apb(1'b1, ADDR_TIMER_GATE_CONTROL, 32'h0);
      apb(1'b1, ADDR_COUNT_LOW, 32'hf0);
      apb(1'b1, ADDR_COUNT_HIGH, 32'hff);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h3);
      chk("irq", 32'h0, 32'(irq));
      apb(1'b1, ADDR_TIMER_CONTROL, 32'h41);
      repeat (30) @(posedge pclk);
      apb(1'b1, ADDR_TIMER_CONTROL, 32'h40);
      count(c);
      rng("wrap", 8'hf0 + 33 - 16'h100, c);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("ovf", 32'h1, rdat & 32'h1);
      chk("irq", 32'h1, 32'(irq));
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      chk("irq", 32'h0, 32'(irq));
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("ovf", 32'h0, rdat & 32'h1);
      report_and_stop();
   end
endmodule
